/* hw/fcb_pkg.sv */
/*
 * Constants, field layouts and carrier types for the second-channel
 * equalizer_fir coefficient bank (taps four to nine).
 * Assumes an APB register port with 32-bit data; register indices are
 * word indices, so the byte address of each register is four times it.
 */
// What this block does
// - Side taps hold 12-bit signed, four reserved bits
// - Coefficients feed filter only in dual mode
// - Taps four to nine at rising offsets
// - Centre tap 18-bit signed, six reserved
// - Ninth tap reads its field MSB as zero
// - All coefficient registers reset to zero
package fcb_pkg;

    // Register indices; byte address is index shifted by FCB_IDX_SHIFT
    localparam int unsigned FCB_IDX_W = 12;
    localparam logic [11:0] FCB_IDX_TAP4 = 12'h44e;
    localparam logic [11:0] FCB_IDX_CENTER = 12'h450;
    localparam logic [11:0] FCB_IDX_TAP6 = 12'h453;
    localparam logic [11:0] FCB_IDX_TAP7 = 12'h455;
    localparam logic [11:0] FCB_IDX_TAP8 = 12'h457;
    localparam logic [11:0] FCB_IDX_TAP9 = 12'h459;
    localparam logic [11:0] FCB_IDX_STATUS = 12'h45b;
    localparam int unsigned FCB_IDX_SHIFT = 2;

    // Field layouts
    localparam int unsigned FCB_TAP_W = 12;
    localparam int unsigned FCB_TAP_REG_W = 16;
    localparam int unsigned FCB_CTR_W = 18;
    localparam int unsigned FCB_CTR_REG_W = 24;
    localparam int unsigned FCB_STAT_DUAL_BIT = 0;

    // Readback of the ninth tap loses the field's top bit
    localparam logic [15:0] FCB_TAP9_RD_MASK = 16'hf7ff;

    // Values after reset
    localparam logic [15:0] FCB_TAP_RST = 16'h0000;
    localparam logic [23:0] FCB_CTR_RST = 24'h000000;
    localparam logic [31:0] FCB_RDATA_RST = 32'h00000000;

    // Coefficient set as presented to the second-channel filter
    typedef struct packed {
        logic signed [11:0] tap4;
        logic signed [17:0] center;
        logic signed [11:0] tap6;
        logic signed [11:0] tap7;
        logic signed [11:0] tap8;
        logic signed [11:0] tap9;
    } fcb_coeff_s;

endpackage : fcb_pkg

/* hw/fcb_coeff_reg.sv */
/*
 * One coefficient register: full-width storage with a write strobe.
 * Assumes the write strobe is a single-cycle pulse from the bus slave.
 */
`timescale 1ns/1ns
module fcb_coeff_reg
    import fcb_pkg::*;
#(
    parameter int unsigned W = 16,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    // Stored value
    output logic [W-1:0] q
);

    // Reserved bits are stored too, so software reads back what it wrote
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST;
        end else if (wr_en) begin
            q <= wdata;
        end
    end

endmodule : fcb_coeff_reg

/* hw/fcb_bank.sv */
/*
 * Second-channel equalizer_fir coefficient bank, taps four to nine,
 * with an APB slave port and a registered coefficient bus to the filter.
 * Assumes an APB3 master (no strobes), pins synchronous to pclk, and a
 * dual_chan_mode level from the mode logic elsewhere in the device.
 */
`timescale 1ns/1ns
module fcb_bank
    import fcb_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Operating mode
    input wire logic dual_chan_mode,
    // Coefficients to the second-channel filter
    output fcb_coeff_s coeff_out,
    output logic coeff_valid
);

    localparam int unsigned WA_W = ADDR_W - FCB_IDX_SHIFT;

    // Stored registers
    logic [15:0] tap4_q;
    logic [23:0] center_q;
    logic [15:0] tap6_q;
    logic [15:0] tap7_q;
    logic [15:0] tap8_q;
    logic [15:0] tap9_q;

    // Bus phase
    wire access = psel && penable;
    wire done = access && pready;
    wire wr_fire = done && pwrite;
    wire word_aligned = (paddr[FCB_IDX_SHIFT-1:0] == '0);
    wire [WA_W-1:0] word_addr = paddr[ADDR_W-1:FCB_IDX_SHIFT];

    // Address decode, one hit per register index
    wire sel_tap4 = word_aligned &&
        (word_addr == WA_W'(FCB_IDX_TAP4));
    wire sel_center = word_aligned &&
        (word_addr == WA_W'(FCB_IDX_CENTER));
    wire sel_tap6 = word_aligned &&
        (word_addr == WA_W'(FCB_IDX_TAP6));
    wire sel_tap7 = word_aligned &&
        (word_addr == WA_W'(FCB_IDX_TAP7));
    wire sel_tap8 = word_aligned &&
        (word_addr == WA_W'(FCB_IDX_TAP8));
    wire sel_tap9 = word_aligned &&
        (word_addr == WA_W'(FCB_IDX_TAP9));
    wire sel_status = word_aligned &&
        (word_addr == WA_W'(FCB_IDX_STATUS));
    wire hit = sel_tap4 || sel_center || sel_tap6 || sel_tap7 ||
        sel_tap8 || sel_tap9 || sel_status;

    // Write strobes; the status register is read only
    wire we_tap4 = wr_fire && sel_tap4;
    wire we_center = wr_fire && sel_center;
    wire we_tap6 = wr_fire && sel_tap6;
    wire we_tap7 = wr_fire && sel_tap7;
    wire we_tap8 = wr_fire && sel_tap8;
    wire we_tap9 = wr_fire && sel_tap9;

    // Side taps keep the 16-bit word, centre the 24-bit word
    wire [15:0] wdata_tap = pwdata[FCB_TAP_REG_W-1:0];
    wire [23:0] wdata_ctr = pwdata[FCB_CTR_REG_W-1:0];

    fcb_coeff_reg #(.W(FCB_TAP_REG_W), .RST(FCB_TAP_RST)) u_tap4 (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(we_tap4),
        .wdata(wdata_tap),
        .q(tap4_q)
    );

    fcb_coeff_reg #(.W(FCB_CTR_REG_W), .RST(FCB_CTR_RST)) u_center (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(we_center),
        .wdata(wdata_ctr),
        .q(center_q)
    );

    fcb_coeff_reg #(.W(FCB_TAP_REG_W), .RST(FCB_TAP_RST)) u_tap6 (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(we_tap6),
        .wdata(wdata_tap),
        .q(tap6_q)
    );

    fcb_coeff_reg #(.W(FCB_TAP_REG_W), .RST(FCB_TAP_RST)) u_tap7 (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(we_tap7),
        .wdata(wdata_tap),
        .q(tap7_q)
    );

    fcb_coeff_reg #(.W(FCB_TAP_REG_W), .RST(FCB_TAP_RST)) u_tap8 (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(we_tap8),
        .wdata(wdata_tap),
        .q(tap8_q)
    );

    // Full value is stored; only the readback path drops the top bit
    fcb_coeff_reg #(.W(FCB_TAP_REG_W), .RST(FCB_TAP_RST)) u_tap9 (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(we_tap9),
        .wdata(wdata_tap),
        .q(tap9_q)
    );

    // Read data, narrower registers zero-extended
    wire [31:0] rd_tap4 = 32'(tap4_q);
    wire [31:0] rd_center = 32'(center_q);
    wire [31:0] rd_tap6 = 32'(tap6_q);
    wire [31:0] rd_tap7 = 32'(tap7_q);
    wire [31:0] rd_tap8 = 32'(tap8_q);
    wire [31:0] rd_tap9 = 32'(tap9_q & FCB_TAP9_RD_MASK);
    wire [31:0] rd_status = 32'(coeff_valid) << FCB_STAT_DUAL_BIT;
    wire [31:0] rd_mux =
        sel_tap4 ? rd_tap4 :
        sel_center ? rd_center :
        sel_tap6 ? rd_tap6 :
        sel_tap7 ? rd_tap7 :
        sel_tap8 ? rd_tap8 :
        sel_tap9 ? rd_tap9 :
        sel_status ? rd_status :
        FCB_RDATA_RST;

    // One wait state keeps pready, prdata and pslverr straight off flops
    wire next_pready = access && !pready;
    wire [31:0] next_prdata = (next_pready && !pwrite) ? rd_mux :
        FCB_RDATA_RST;
    wire next_pslverr = next_pready && !hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= FCB_RDATA_RST;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Filter sees only the signed fields; single mode drives zeros
    fcb_coeff_s next_coeff;
    assign next_coeff.tap4 = tap4_q[FCB_TAP_W-1:0];
    assign next_coeff.center = center_q[FCB_CTR_W-1:0];
    assign next_coeff.tap6 = tap6_q[FCB_TAP_W-1:0];
    assign next_coeff.tap7 = tap7_q[FCB_TAP_W-1:0];
    assign next_coeff.tap8 = tap8_q[FCB_TAP_W-1:0];
    assign next_coeff.tap9 = tap9_q[FCB_TAP_W-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coeff_out <= '0;
            coeff_valid <= 1'b0;
        end else begin
            coeff_out <= dual_chan_mode ? next_coeff : '0;
            coeff_valid <= dual_chan_mode;
        end
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire rd_done = done && !pwrite;

    AST_TAP_WRITE_STORES: assert property (
        we_tap4 |=> tap4_q == $past(pwdata[15:0])
    ) else $error("tap4 write not stored");

    AST_CENTER_WRITE_STORES: assert property (
        we_center |=> center_q == $past(pwdata[23:0])
    ) else $error("centre tap write not stored in full");

    AST_CENTER_READ_WIDTH: assert property (
        rd_done && sel_center |->
            prdata[31:24] == 8'h00 && prdata[23:0] == center_q
    ) else $error("centre tap readback wrong");

    AST_TAP9_MSB_READ_ZERO: assert property (
        rd_done && sel_tap9 |->
            prdata[FCB_TAP_W-1] == 1'b0 &&
            prdata[10:0] == tap9_q[10:0]
    ) else $error("ninth tap readback top bit not zero");

    AST_TAP9_STORES_FULL: assert property (
        we_tap9 && pwdata[FCB_TAP_W-1] |=> tap9_q[FCB_TAP_W-1] ##1
            (!$past(dual_chan_mode) || coeff_out.tap9[FCB_TAP_W-1])
    ) else $error("ninth tap top bit lost on store");

    AST_SINGLE_MODE_ZERO: assert property (
        !dual_chan_mode |=> coeff_out == '0 && !coeff_valid
    ) else $error("coefficients applied outside dual mode");

    AST_TAP_ORDER: assert property (
        dual_chan_mode |=>
            coeff_out.tap4 == $past(tap4_q[11:0]) &&
            coeff_out.tap6 == $past(tap6_q[11:0]) &&
            coeff_out.tap9 == $past(tap9_q[11:0])
    ) else $error("tap order or value wrong on filter bus");

    AST_RESERVED_NO_EFFECT: assert property (
        dual_chan_mode && we_tap7 |=> ##1
            coeff_out.tap7 == $past(pwdata[11:0], 2)
    ) else $error("reserved bits reach the filter");

    AST_READ_BACK: assert property (
        rd_done && sel_tap8 |-> prdata == 32'(tap8_q)
    ) else $error("tap8 readback wrong");

    AST_RESET_ZERO: assert property (
        @(posedge pclk) disable iff (1'b0)
        !presetn |-> tap4_q == '0 && center_q == '0 && tap6_q == '0 &&
            tap7_q == '0 && tap8_q == '0 && tap9_q == '0
    ) else $error("coefficient not zero in reset");

    AST_ONE_WAIT_STATE: assert property (
        access && !pready |=> pready ##1 !pready
    ) else $error("access phase length wrong");

    AST_SLVERR_WITH_READY: assert property (
        pslverr |-> pready
    ) else $error("error flag without ready");

    AST_UNMAPPED_ERROR: assert property (
        done && !hit |-> pslverr && prdata == FCB_RDATA_RST
    ) else $error("unmapped access not refused");

    AST_MAPPED_NO_ERROR: assert property (
        done && hit |-> !pslverr
    ) else $error("mapped access refused");

    // A refused address must not touch any stored coefficient
    AST_UNMAPPED_WRITE_IGNORED: assert property (
        wr_fire && !hit |=>
            tap4_q == $past(tap4_q) && center_q == $past(center_q) &&
            tap6_q == $past(tap6_q) && tap7_q == $past(tap7_q) &&
            tap8_q == $past(tap8_q) && tap9_q == $past(tap9_q)
    ) else $error("refused write changed a coefficient");

    AST_WRITE_DATA_ZERO: assert property (
        done && pwrite |-> prdata == FCB_RDATA_RST
    ) else $error("read data driven during a write");

    AST_IDLE_OUTPUTS_LOW: assert property (
        !access |=> !pready && !pslverr && prdata == FCB_RDATA_RST
    ) else $error("bus answer outside an access phase");

    // Status reports the mode as the filter saw it one cycle earlier
    AST_STATUS_READ: assert property (
        rd_done && sel_status |-> prdata == 32'($past(coeff_valid))
    ) else $error("status readback wrong");

    AST_DUAL_VALID: assert property (
        dual_chan_mode |=> coeff_valid
    ) else $error("dual mode not flagged to the filter");

    AST_FILTER_CENTER: assert property (
        dual_chan_mode |=>
            coeff_out.center == $past(center_q[17:0]) &&
            coeff_out.tap7 == $past(tap7_q[11:0]) &&
            coeff_out.tap8 == $past(tap8_q[11:0])
    ) else $error("centre or middle taps wrong on filter bus");

    AST_TAP6_READ_BACK: assert property (
        rd_done && sel_tap6 |-> prdata == 32'(tap6_q)
    ) else $error("tap6 readback wrong");

    AST_COEFF_HOLD: assert property (
        (dual_chan_mode && !wr_fire) ##1 dual_chan_mode |=>
            $stable(coeff_out)
    ) else $error("filter bus moved without a write");

    COV_WRITE_TAP9: cover property (we_tap9 && pwdata[FCB_TAP_W-1]);
    COV_READ_TAP9: cover property (rd_done && sel_tap9);
    COV_MODE_ON: cover property ($rose(dual_chan_mode));
    COV_UNMAPPED: cover property (done && pslverr);
    COV_WRITE_DUAL: cover property (dual_chan_mode && we_tap7);

endmodule : fcb_bank

/* tb/fcb_bank_tb.sv */
/*
 * Self-checking bench for the second-channel coefficient bank.
 * Assumes fcb_bank with a 16-bit APB address and one 50 MHz clock;
 * the bench is the APB master and drives the mode level itself.
 */
`timescale 1ns/1ns
module fcb_bank_tb;
    import fcb_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic dual_chan_mode = 1'b0;
    fcb_coeff_s coeff_out;
    logic coeff_valid;
    int n_mismatch = 0;
    int check_count = 0;
    integer seed = 63;
    logic [11:0] idx [6];
    logic [23:0] model [6];
    logic [31:0] rd;
    logic [31:0] d;
    logic err;

    always #10 pclk = ~pclk;

    fcb_bank #(.ADDR_W(16)) fcb_bank_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr),
        .dual_chan_mode(dual_chan_mode), .coeff_out(coeff_out),
        .coeff_valid(coeff_valid)
    );

    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask : chk

    // Holds the request until pready is seen high at a rising edge
    task apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: pready never came", $time);
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [15:0] addr_of(input int i);
        return {2'b00, idx[i], 2'b00};
    endfunction : addr_of

    // Ninth tap loses its field top bit on readback only
    function automatic logic [31:0] exp_rd(input int i);
        if (i == 1) return {8'h00, model[1]};
        if (i == 5) return {16'h0000, model[5][15:0] & 16'hf7ff};
        return {16'h0000, model[i][15:0]};
    endfunction : exp_rd

    function automatic fcb_coeff_s exp_coeff();
        fcb_coeff_s e;
        e.tap4 = model[0][11:0];
        e.center = model[1][17:0];
        e.tap6 = model[2][11:0];
        e.tap7 = model[3][11:0];
        e.tap8 = model[4][11:0];
        e.tap9 = model[5][11:0];
        return e;
    endfunction : exp_coeff

    task chk_coeff(input fcb_coeff_s e, input logic v);
        check_count++;
        if (coeff_out !== e || coeff_valid !== v) begin
            n_mismatch++;
            $display("mismatch at %0t: coeff bus %h", $time, coeff_out);
        end
    endtask : chk_coeff

    task check_all(input string s);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, addr_of(i), 32'h00000000);
            chk(rd, exp_rd(i), s);
        end
    endtask : check_all

    initial begin
        idx = '{FCB_IDX_TAP4, FCB_IDX_CENTER, FCB_IDX_TAP6, FCB_IDX_TAP7,
                FCB_IDX_TAP8, FCB_IDX_TAP9};
        model = '{default: 24'h000000};
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check_all("reset value");
        chk_coeff('0, 1'b0);
        $display("test reset values done");
        // Corners first: all ones, then the most negative side tap
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 6; i++) begin
                d = (r == 0) ? 32'hffffffff : (r == 1) ? 32'h00020800 : $random(seed);
                apb(1'b1, addr_of(i), d);
                model[i] = (i == 1) ? d[23:0] : {8'h00, d[15:0]};
                chk({31'h0, err}, 32'h0, "write error");
                chk(rd, 32'h00000000, "write read data");
            end
            check_all("readback");
            chk_coeff('0, 1'b0);
            dual_chan_mode <= 1'b1;
            repeat (3) @(posedge pclk);
            chk_coeff(exp_coeff(), 1'b1);
            apb(1'b0, {2'b00, FCB_IDX_STATUS, 2'b00}, 32'h00000000);
            chk(rd, 32'h00000001, "status dual");
            // Write while the filter is live; reserved bits must not leak
            d = $random(seed);
            apb(1'b1, addr_of(3), d);
            model[3] = {8'h00, d[15:0]};
            repeat (2) @(posedge pclk);
            chk_coeff(exp_coeff(), 1'b1);
            dual_chan_mode <= 1'b0;
            repeat (3) @(posedge pclk);
            chk_coeff('0, 1'b0);
            apb(1'b0, {2'b00, FCB_IDX_STATUS, 2'b00}, 32'h00000000);
            chk(rd, 32'h00000000, "status single");
            $display("test round %0d done", r);
        end
        apb(1'b0, 16'h1000, 32'h00000000);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        apb(1'b1, addr_of(0) + 16'h0001, 32'h0000ffff);
        chk({31'h0, err}, 32'h1, "unaligned error");
        check_all("after refused write");
        $display("test refused access done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        model = '{default: 24'h000000};
        check_all("second reset");
        $display("test second reset done");
        end_of_test();
    end
endmodule : fcb_bank_tb
